//--- design/aoc_fifo.sv
// Sample FIFO with registered read side and valid/ready on both sides.
`timescale 1ns/1ps
module aoc_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic         IN_VALID,
  output logic              IN_READY,
  input  wire logic [W-1:0] IN_DATA,
  output logic              OUT_VALID,
  input  wire logic         OUT_READY,
  output logic      [W-1:0] OUT_DATA
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          ov_r, ov_nxt;
  logic [W-1:0]  od_r, od_nxt;
  logic          push, pop;

  assign IN_READY  = (cnt_r != DEPTH[AW:0]);
  assign OUT_VALID = ov_r;
  assign OUT_DATA  = od_r;

  always_comb begin
    push    = IN_VALID && IN_READY;
    pop     = (cnt_r != '0) && (!ov_r || OUT_READY);
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ov_nxt  = pop ? 1'b1 : (OUT_READY ? 1'b0 : ov_r);
    od_nxt  = pop ? mem_r[rp_r] : od_r;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ov_r  <= 1'b0;
      od_r  <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem_r[wp_r] <= IN_DATA;
    end
  end

endmodule // aoc_fifo

//--- design/aoc_pin_sync.sv
// Three-stage synchroniser for pin inputs with agreement filter.
`timescale 1ns/1ps
module aoc_pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] PIN_IN,
  output logic      [W-1:0] PIN_OUT
);

  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    out_nxt = (s3_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      s1_r  <= PIN_IN;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign PIN_OUT = out_r;

endmodule // aoc_pin_sync

//--- design/aoc_pkg.sv
// Constants and states of the converter output and calibration control.
// How it works
// - Each sample leaves on the output word exactly 28 sample cycles after capture.
// - Reference select low chooses the internal reference, high the external one.
// - Clock-halving select low halves the sample rate, high passes it through.
// - The calibration reset line is active low; low holds the block in reset.
// - After power-up the block drives the line low while trimming, and releases it for the settle cycles before calibration finishes.
// - Start-up calibration trims offset before normal samples are delivered; gain comes from the trim register. SAMPLE_WORD keeps updating; FIFO writes wait.
// - An external low on the line after power-up restarts reset and calibration.
// - Two's-complement select low gives two's complement, high gives straight binary.
// - The sample word is eight bits wide, bit 0 least and bit 7 most significant.
// - Two output codings exist: two's complement and straight binary.
// - The halving divider toggles on rising edges only, giving an even duty cycle.
// - Reset, halving and coding inputs default to their inactive level when open.
package aoc_pkg;

  localparam int          SAMPLE_W      = 8;
  localparam int          LATENCY       = 28;
  localparam int          PIPE_STAGES   = 24;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_W        = SAMPLE_W + 1;
  localparam int          CAL_LOG2      = 8;
  localparam int          SETTLE_CYCLES = 4;
  localparam int          CNT_W         = 16;

  localparam logic [7:0]  MID_CODE      = 8'h80;
  localparam logic [7:0]  GAIN_UNITY    = 8'h80;
  localparam int          GAIN_SHIFT    = 7;

  // Pin defaults applied in reset, as an open input would read.
  localparam logic        PIN_DEFAULT   = 1'b1;

  // Register byte offsets.
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam logic [3:0]  OFS_TRIM      = 4'h8;
  localparam logic [3:0]  OFS_DATA      = 4'hc;

  // Field positions.
  localparam int          CTRL_RECAL    = 0;
  localparam int          CTRL_FIFO_EN  = 1;
  localparam int          ST_CAL        = 0;
  localparam int          ST_NEMPTY     = 1;
  localparam int          ST_FULL       = 2;
  localparam int          ST_OVF        = 3;
  localparam int          ST_EXT_REF    = 4;
  localparam int          ST_HALVE      = 5;
  localparam int          DATA_VALID    = 31;

  localparam logic        FIFO_EN_RST   = 1'b1;

  typedef enum logic [1:0] {
    CAL_HOLD,
    CAL_RUN_TRIM,
    CAL_SETTLE,
    CAL_DONE
  } aoc_cal_state_t;

endpackage

//--- design/aoc_top.sv
// Output, coding, clock halving and calibration control of the converter.
`timescale 1ns/1ps
module aoc_top #(
  parameter int CAL_LOG2 = aoc_pkg::CAL_LOG2,
  parameter int LATENCY  = aoc_pkg::LATENCY
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  CONV_CODE,
  input  wire logic        CONV_OVER_RANGE,
  input  wire logic        CAL_RESET_N_I,
  output logic             CAL_RESET_N_O,
  output logic             CAL_RESET_N_OE,
  input  wire logic        CLOCK_HALVING_SELECT_N,
  input  wire logic        TWOS_COMPLEMENT_SELECT_N,
  input  wire logic        REFERENCE_SOURCE_SELECT,
  output logic             REFERENCE_USE_EXTERNAL,
  output logic [7:0]       SAMPLE_WORD,
  output logic             OVER_RANGE_FLAG,
  output logic             SAMPLE_CLOCK_OUT,
  output logic             CALIBRATING,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       rst_pin_s, halve_n_s, twos_n_s, ext_ref_s;

  aoc_pin_sync #(
    .W       (4),
    .RST_VAL ({4{aoc_pkg::PIN_DEFAULT}})
  ) u_sync (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .PIN_IN  ({CAL_RESET_N_I, CLOCK_HALVING_SELECT_N,
               TWOS_COMPLEMENT_SELECT_N, REFERENCE_SOURCE_SELECT}),
    .PIN_OUT (pins_s)
  );

  assign rst_pin_s = pins_s[3];
  assign halve_n_s = pins_s[2];
  assign twos_n_s  = pins_s[1];
  assign ext_ref_s = pins_s[0];

  // ----------------------------------------------------------------
  // Sample rate divider
  // ----------------------------------------------------------------
  logic tog_r, tog_nxt, smp_en;

  always_comb begin
    tog_nxt = ~tog_r;
    smp_en  = halve_n_s ? 1'b1 : tog_r;
  end

  // ----------------------------------------------------------------
  // Calibration control
  // ----------------------------------------------------------------
  localparam int ACC_W = aoc_pkg::SAMPLE_W + CAL_LOG2 + 2;

  aoc_pkg::aoc_cal_state_t cst_r, cst_nxt;
  logic [aoc_pkg::CNT_W-1:0] ccnt_r, ccnt_nxt;
  logic signed [ACC_W-1:0]   acc_r, acc_nxt;
  logic signed [7:0]         ofs_r, ofs_nxt;
  logic                      recal_req;
  logic signed [ACC_W-1:0]   dev;
  logic signed [ACC_W-1:0]   acc_sh;

  always_comb begin
    cst_nxt  = cst_r;
    ccnt_nxt = ccnt_r;
    acc_nxt  = acc_r;
    ofs_nxt  = ofs_r;
    dev      = ACC_W'($signed({1'b0, CONV_CODE}))
             - ACC_W'($signed({1'b0, aoc_pkg::MID_CODE}));
    acc_sh   = acc_r >>> CAL_LOG2;
    unique case (cst_r)
      aoc_pkg::CAL_HOLD: begin
        ccnt_nxt = '0;
        acc_nxt  = '0;
        if (rst_pin_s) begin
          cst_nxt = aoc_pkg::CAL_RUN_TRIM;
        end
      end
      aoc_pkg::CAL_RUN_TRIM: begin
        if (smp_en) begin
          acc_nxt  = acc_r + dev;
          ccnt_nxt = ccnt_r + 1'b1;
          if (ccnt_r == aoc_pkg::CNT_W'((1 << CAL_LOG2) - 1)) begin
            cst_nxt  = aoc_pkg::CAL_SETTLE;
            ccnt_nxt = '0;
          end
        end
      end
      aoc_pkg::CAL_SETTLE: begin
        ofs_nxt  = acc_sh[7:0];
        ccnt_nxt = ccnt_r + 1'b1;
        if (ccnt_r == aoc_pkg::CNT_W'(aoc_pkg::SETTLE_CYCLES - 1)) begin
          cst_nxt = aoc_pkg::CAL_DONE;
        end
      end
      aoc_pkg::CAL_DONE: begin
        if (!rst_pin_s || recal_req) begin
          cst_nxt = aoc_pkg::CAL_HOLD;
        end
      end
    endcase
  end

  // The line is pulled low while trimming and is never driven high.
  // The settle time lets its synchronised read-back return high first.
  assign CAL_RESET_N_O  = 1'b0;
  assign CAL_RESET_N_OE = (cst_r == aoc_pkg::CAL_RUN_TRIM);
  assign CALIBRATING    = (cst_r != aoc_pkg::CAL_DONE);

  // ----------------------------------------------------------------
  // Conversion pipeline and output stage
  // ----------------------------------------------------------------
  logic [8:0] pipe_r   [LATENCY-1];
  logic [8:0] pipe_nxt [LATENCY-1];

  genvar gi;
  generate
    for (gi = 0; gi < LATENCY - 1; gi++) begin : g_pipe
      always_comb begin
        if (!smp_en) begin
          pipe_nxt[gi] = pipe_r[gi];
        end else if (gi == 0) begin
          pipe_nxt[gi] = {CONV_OVER_RANGE, CONV_CODE};
        end else begin
          pipe_nxt[gi] = pipe_r[(gi == 0) ? 0 : gi - 1];
        end
      end
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          pipe_r[gi] <= '0;
        end else begin
          pipe_r[gi] <= pipe_nxt[gi];
        end
      end
    end
  endgenerate

  logic [7:0]         gain_r, gain_nxt;
  logic signed [17:0] corr;
  logic [7:0]         code_c;
  logic               or_c;
  logic [7:0]         word_r, word_nxt;
  logic               orf_r, orf_nxt, sco_r, sco_nxt, ext_r;
  logic [8:0]         tail;

  always_comb begin
    tail = pipe_r[LATENCY-2];
    corr = (18'($signed({1'b0, tail[7:0]}))
          - 18'($signed({1'b0, aoc_pkg::MID_CODE}))
          - 18'(ofs_r)) * 18'($signed({1'b0, gain_r}));
    corr = (corr >>> aoc_pkg::GAIN_SHIFT)
         + 18'($signed({1'b0, aoc_pkg::MID_CODE}));
    or_c = tail[8];
    if (corr < 0) begin
      code_c = 8'h00;
      or_c   = 1'b1;
    end else if (corr > 18'sd255) begin
      code_c = 8'hff;
      or_c   = 1'b1;
    end else begin
      code_c = corr[7:0];
    end
    word_nxt = word_r;
    orf_nxt  = orf_r;
    sco_nxt  = 1'b0;
    if (smp_en) begin
      word_nxt = twos_n_s ? code_c
                          : {~code_c[7], code_c[6:0]};
      orf_nxt  = or_c;
      sco_nxt  = 1'b1;
    end
  end

  assign SAMPLE_WORD            = word_r;
  assign OVER_RANGE_FLAG        = orf_r;
  assign SAMPLE_CLOCK_OUT       = sco_r;
  assign REFERENCE_USE_EXTERNAL = ext_r;

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  logic       fifo_en_r, fifo_en_nxt, fin_ready, fout_valid, fout_ready;
  logic [8:0] fout_data;

  aoc_fifo #(
    .W     (aoc_pkg::FIFO_W),
    .DEPTH (aoc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .IN_VALID  (sco_r && fifo_en_r && !CALIBRATING),
    .IN_READY  (fin_ready),
    .IN_DATA   ({orf_r, word_r}),
    .OUT_VALID (fout_valid),
    .OUT_READY (fout_ready),
    .OUT_DATA  (fout_data)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        acc_ok, wr_pend_r, wr_pend_nxt, ovf_r, ovf_nxt;
  logic [3:0]  wadr_r, wadr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        w_ctrl, w_stat, w_trim;

  always_comb begin
    acc_ok      = HSEL && HTRANS[1] && HREADY;
    wr_pend_nxt = acc_ok && HWRITE;
    wadr_nxt    = acc_ok ? HADDR[3:0] : wadr_r;
    fout_ready  = acc_ok && !HWRITE && (HADDR[3:0] == aoc_pkg::OFS_DATA);
    w_ctrl      = wr_pend_r && (wadr_r == aoc_pkg::OFS_CTRL);
    w_stat      = wr_pend_r && (wadr_r == aoc_pkg::OFS_STATUS);
    w_trim      = wr_pend_r && (wadr_r == aoc_pkg::OFS_TRIM);
    recal_req   = w_ctrl && HWDATA[aoc_pkg::CTRL_RECAL];
    fifo_en_nxt = w_ctrl ? HWDATA[aoc_pkg::CTRL_FIFO_EN] : fifo_en_r;
    gain_nxt    = w_trim ? HWDATA[15:8] : gain_r;
    ovf_nxt     = ovf_r;
    if (w_stat && HWDATA[aoc_pkg::ST_OVF]) begin
      ovf_nxt = 1'b0;
    end
    if (sco_r && fifo_en_r && !CALIBRATING && !fin_ready) begin
      ovf_nxt = 1'b1;
    end
    rdata_nxt = 32'h0000_0000;
    if (acc_ok && !HWRITE) begin
      unique case (HADDR[3:0])
        aoc_pkg::OFS_CTRL:   rdata_nxt[aoc_pkg::CTRL_FIFO_EN] = fifo_en_r;
        aoc_pkg::OFS_STATUS: begin
          rdata_nxt[aoc_pkg::ST_CAL]     = CALIBRATING;
          rdata_nxt[aoc_pkg::ST_NEMPTY]  = fout_valid;
          rdata_nxt[aoc_pkg::ST_FULL]    = !fin_ready;
          rdata_nxt[aoc_pkg::ST_OVF]     = ovf_r;
          rdata_nxt[aoc_pkg::ST_EXT_REF] = ext_r;
          rdata_nxt[aoc_pkg::ST_HALVE]   = !halve_n_s;
        end
        aoc_pkg::OFS_TRIM:   rdata_nxt[15:0] = {gain_r, ofs_r};
        aoc_pkg::OFS_DATA:   rdata_nxt = {fout_valid, 22'h000000, fout_data};
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  assign HRDATA    = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tog_r     <= 1'b0;
      cst_r     <= aoc_pkg::CAL_HOLD;
      ccnt_r    <= '0;
      acc_r     <= '0;
      ofs_r     <= '0;
      gain_r    <= aoc_pkg::GAIN_UNITY;
      word_r    <= 8'h00;
      orf_r     <= 1'b0;
      sco_r     <= 1'b0;
      ext_r     <= aoc_pkg::PIN_DEFAULT;
      fifo_en_r <= aoc_pkg::FIFO_EN_RST;
      ovf_r     <= 1'b0;
      wr_pend_r <= 1'b0;
      wadr_r    <= 4'h0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      tog_r     <= tog_nxt;
      cst_r     <= cst_nxt;
      ccnt_r    <= ccnt_nxt;
      acc_r     <= acc_nxt;
      ofs_r     <= ofs_nxt;
      gain_r    <= gain_nxt;
      word_r    <= word_nxt;
      orf_r     <= orf_nxt;
      sco_r     <= sco_nxt;
      ext_r     <= ext_ref_s;
      fifo_en_r <= fifo_en_nxt;
      ovf_r     <= ovf_nxt;
      wr_pend_r <= wr_pend_nxt;
      wadr_r    <= wadr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

endmodule // aoc_top

//--- tb/aoc_capture_model.sv
// Capture receiver at the far side of the sample output, with reset pull.
`timescale 1ns/1ps
module aoc_capture_model (
  input  wire logic       clk,
  input  wire logic [7:0] sample_word,
  input  wire logic       over_range_flag,
  input  wire logic       sample_clock_out,
  input  wire logic       pull_req,
  output logic            pull_en,
  output logic [8:0]      cap_word,
  output int              cap_cnt
);
  logic [3:0] hold_r = 4'h0;
  initial cap_cnt = 0;
  always @(posedge clk) begin
    if (sample_clock_out) begin
      cap_word <= {over_range_flag, sample_word};
      cap_cnt  <= cap_cnt + 1;
    end
    if (pull_req)
      hold_r <= 4'ha;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  end
  // The line is only pulled low, never driven high.
  assign pull_en = pull_req || (hold_r != 4'h0);
endmodule // aoc_capture_model

//--- tb/aoc_chk_sva.sv
// Assertion checker bound to the converter output and calibration control.
`timescale 1ns/1ps
module aoc_chk #(
  parameter int CAL_LOG2 = 8,
  parameter int LATENCY  = 28
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CONV_OVER_RANGE,
  input wire logic CAL_RESET_N_I,
  input wire logic CAL_RESET_N_O,
  input wire logic CAL_RESET_N_OE,
  input wire logic CLOCK_HALVING_SELECT_N,
  input wire logic REFERENCE_SOURCE_SELECT,
  input wire logic REFERENCE_USE_EXTERNAL,
  input wire logic OVER_RANGE_FLAG,
  input wire logic SAMPLE_CLOCK_OUT,
  input wire logic CALIBRATING
);
  localparam int CAL_MAX = 2 * (2 ** CAL_LOG2) + 40;
  logic [6:0] full_r;
  logic [6:0] half_r;
  logic [6:0] full_nxt;
  logic [6:0] half_nxt;
  // Counts cycles spent steadily in one rate mode.
  always_comb begin
    full_nxt = 7'h00;
    half_nxt = 7'h00;
    if (CLOCK_HALVING_SELECT_N)
      full_nxt = (full_r == 7'h64) ? full_r : full_r + 7'h01;
    else
      half_nxt = (half_r == 7'h64) ? half_r : half_r + 7'h01;
  end
  always_ff @(posedge CLK) begin
    full_r <= RST_N ? full_nxt : 7'h00;
    half_r <= RST_N ? half_nxt : 7'h00;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_cal_busy; CALIBRATING [*8]; endsequence
  sequence s_cal_done; !CALIBRATING && !CAL_RESET_N_OE; endsequence
  property p_cal_after_reset;
    $rose(RST_N) |-> s_cal_busy ##[1:CAL_MAX] s_cal_done;
  endproperty
  property p_pull_at_start;
    $rose(RST_N) |-> ##[1:12] CAL_RESET_N_OE;
  endproperty
  property p_oe_in_cal;
    !CAL_RESET_N_O && (!CAL_RESET_N_OE || CALIBRATING);
  endproperty
  property p_release_done;
    $fell(CAL_RESET_N_OE) |-> CALIBRATING ##[1:8] s_cal_done;
  endproperty
  property p_pin_holds; (!CAL_RESET_N_I) [*8] |-> CALIBRATING; endproperty
  property p_ref_follow;
    $stable(REFERENCE_SOURCE_SELECT) [*8]
      |-> REFERENCE_USE_EXTERNAL == REFERENCE_SOURCE_SELECT;
  endproperty
  property p_full_rate; full_r == 7'h64 |-> SAMPLE_CLOCK_OUT; endproperty
  property p_half_duty;
    half_r == 7'h64 |-> SAMPLE_CLOCK_OUT != $past(SAMPLE_CLOCK_OUT);
  endproperty
  property p_or_latency;
    full_r == 7'h64 && $past(CONV_OVER_RANGE, LATENCY) |-> OVER_RANGE_FLAG;
  endproperty
  a_cal_after_reset: assert property (p_cal_after_reset)
    else $error("calibration did not run and end after reset");
  a_pull_at_start: assert property (p_pull_at_start)
    else $error("reset line not pulled low after reset");
  a_oe_in_cal: assert property (p_oe_in_cal)
    else $error("reset line driven outside calibration or high");
  a_release_done: assert property (p_release_done)
    else $error("calibration did not end soon after line release");
  a_pin_holds: assert property (p_pin_holds)
    else $error("low reset line did not hold calibration");
  a_ref_follow: assert property (p_ref_follow)
    else $error("reference choice does not follow its select");
  a_full_rate: assert property (p_full_rate)
    else $error("output clock missing at full rate");
  a_half_duty: assert property (p_half_duty)
    else $error("halved output clock does not alternate");
  a_or_latency: assert property (p_or_latency)
    else $error("over-range flag lost or misaligned");
endmodule // aoc_chk

bind aoc_top aoc_chk #(.CAL_LOG2(CAL_LOG2), .LATENCY(LATENCY)) chk_u (
  .CLK(CLK), .RST_N(RST_N), .CONV_OVER_RANGE(CONV_OVER_RANGE),
  .CAL_RESET_N_I(CAL_RESET_N_I), .CAL_RESET_N_O(CAL_RESET_N_O),
  .CAL_RESET_N_OE(CAL_RESET_N_OE),
  .CLOCK_HALVING_SELECT_N(CLOCK_HALVING_SELECT_N),
  .REFERENCE_SOURCE_SELECT(REFERENCE_SOURCE_SELECT),
  .REFERENCE_USE_EXTERNAL(REFERENCE_USE_EXTERNAL),
  .OVER_RANGE_FLAG(OVER_RANGE_FLAG), .SAMPLE_CLOCK_OUT(SAMPLE_CLOCK_OUT),
  .CALIBRATING(CALIBRATING));

//--- tb/aoc_top_tb.sv
// Self-checking testbench of the converter output and calibration control.
`timescale 1ns/1ps
module aoc_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  code = 8'h80;
  logic        ovr = 1'b0;
  logic        pin_pull = 1'b0;
  logic        halve_n = 1'b1;
  logic        tc_n = 1'b1;
  logic        ref_sel = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, r;
  logic [7:0]  sw;
  logic        oe, drv, ref_ext, orf, sco, cal, hready, pull_en;
  logic        quiet = 1'b1;
  logic        chk_on = 1'b0;
  logic [8:0]  hist [64];
  logic [5:0]  wp = 6'h0;
  int          cap_cnt, n0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          seed = 21922;
  wire         pin = oe ? drv && !pull_en : !pull_en;

  aoc_top #(.CAL_LOG2(2), .LATENCY(aoc_pkg::LATENCY)) dut_u (
    .CLK(clk), .RST_N(rst_n), .CONV_CODE(code), .CONV_OVER_RANGE(ovr),
    .CAL_RESET_N_I(pin), .CAL_RESET_N_O(drv), .CAL_RESET_N_OE(oe),
    .CLOCK_HALVING_SELECT_N(halve_n), .TWOS_COMPLEMENT_SELECT_N(tc_n),
    .REFERENCE_SOURCE_SELECT(ref_sel), .REFERENCE_USE_EXTERNAL(ref_ext),
    .SAMPLE_WORD(sw), .OVER_RANGE_FLAG(orf), .SAMPLE_CLOCK_OUT(sco),
    .CALIBRATING(cal), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP());
  aoc_capture_model far_u (
    .clk(clk), .sample_word(sw), .over_range_flag(orf),
    .sample_clock_out(sco), .pull_req(pin_pull), .pull_en(pull_en),
    .cap_word(), .cap_cnt(cap_cnt));

  // The period never changes, so no calibration is invalidated.
  initial forever #25 clk = ~clk;

  function automatic logic [8:0] expw(input logic [8:0] h);
    return {h[8], h[7] ^ !tc_n, h[6:0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_cal(input logic v);
    for (int i = 0; i < 900 && cal !== v; i++) @(posedge clk);
    check("calibrating", 32'(cal), 32'(v));
  endtask

  task automatic close_out();
    $display("compared %0d wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Random codes with corner values mixed in, and the output scoreboard.
  always @(posedge clk) begin
    r = $random(seed);
    code <= quiet ? 8'h80 : (r[4:3] == 2'h0) ? {r[1], {7{r[0]}}} : r[15:8];
    ovr <= !quiet && r[20];
    hist[wp] = {ovr, code};
    if (chk_on && sco)
      check("word", 32'({orf, sw}),
            32'(expw(hist[wp - 6'd28])));
    wp <= wp + 6'h1;
  end

  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_cal(1'b0);
    repeat (30) @(posedge clk);
    bus(32'h4, 1'b0, 32'h0);
    check("status", rd, 32'h1e);
    bus(32'h8, 1'b0, 32'h0);
    check("trim", rd, 32'h8000);
    bus(32'h14, 1'b0, 32'h0);
    check("status alias", rd, 32'h1e);
    bus(32'h0, 1'b1, 32'h0);
    bus(32'h4, 1'b1, 32'h8);
    bus(32'hc, 1'b0, 32'h0);
    check("data valid", 32'(rd[31]), 32'h1);
    repeat (20) bus(32'hc, 1'b0, 32'h0);
    bus(32'h4, 1'b0, 32'h0);
    check("drained", rd, 32'h10);
    bus(32'h0, 1'b1, 32'h2);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      tc_n <= m[0];
      quiet <= 1'b0;
      repeat (60) @(posedge clk);
      chk_on <= 1'b1;
      repeat (200) @(posedge clk);
      chk_on <= 1'b0;
    end
    $display("test coding done");
    halve_n <= 1'b0;
    repeat (80) @(posedge clk);
    n0 = cap_cnt;
    repeat (40) @(posedge clk);
    check("pulses", 32'(cap_cnt - n0), 32'd20);
    halve_n <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      ref_sel <= v[0];
      repeat (10) @(posedge clk);
      check("reference", 32'(ref_ext), 32'(v));
    end
    $display("test modes done");
    quiet <= 1'b1;
    pin_pull <= 1'b1;
    @(posedge clk);
    pin_pull <= 1'b0;
    repeat (9) @(posedge clk);
    check("pin recal", 32'(cal), 32'h1);
    wait_cal(1'b0);
    bus(32'h0, 1'b1, 32'h3);
    repeat (8) @(posedge clk);
    check("ctrl recal", 32'(cal), 32'h1);
    wait_cal(1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_cal(1'b0);
    $display("test recalibration done");
    close_out();
  end
endmodule // aoc_top_tb
